// File: logic/seconds_watchdog_timer.sv
// Seconds watchdog timer with APB register access
module seconds_watchdog_timer #(
  parameter int TICK_CYCLES = wdog_pkg::TICK_CYCLES
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [7:0]  o_irq_lines,
  output logic             o_board_reset,
  output logic             o_timeout
);

  typedef struct packed {
    logic [7:0]  count;
    logic        enable;
    logic        irq_en;
    logic        rst_en;
    logic [2:0]  irq_sel;
    logic        timeout;
    logic [26:0] prescale;
    logic        tick;
    logic [7:0]  pulse;
    logic        board_reset;
    logic [7:0]  irq_lines;
    logic [31:0] prdata;
    logic        pslverr;
  } state_type;

  state_type state;
  state_type next_state;

  logic       access;
  logic       wr_count;
  logic       wr_control;
  logic       known_addr;
  logic       trigger;
  logic [7:0] irq_hit;

  // APB access decode; slave answers in the first access cycle
  assign access     = i_psel && i_penable;
  assign known_addr = (i_paddr == wdog_pkg::COUNT_ADDR) || (i_paddr == wdog_pkg::CONTROL_ADDR)
                      || (i_paddr == wdog_pkg::STATUS_ADDR);
  assign wr_count   = access && i_pwrite && i_pstrb[0] && (i_paddr == wdog_pkg::COUNT_ADDR);
  assign wr_control = access && i_pwrite && i_pstrb[0] && (i_paddr == wdog_pkg::CONTROL_ADDR);
  // Zero count while enabled fires, also right at enable
  // A count write replaces the zero, so it acknowledges the expiry
  assign trigger    = state.enable && (state.count == wdog_pkg::COUNT_ZERO)
                      && !wr_count;

  // One decoder per interrupt line; only the selected line follows the flag
  for (genvar idx = 0; idx < wdog_pkg::IRQ_LINES; idx++)
  begin : g_irq_route
    assign irq_hit[idx] = state.timeout && state.irq_en
                          && (state.irq_sel == 3'(idx));
  end

  // Next-state logic
  always_comb
  begin
    next_state      = state;
    next_state.tick = 1'b0;
    // One-second prescaler runs only while enabled
    if (!state.enable)
    begin
      next_state.prescale = '0;
    end
    else if (state.prescale == 27'(TICK_CYCLES - 1))
    begin
      next_state.prescale = '0;
      next_state.tick     = 1'b1;
    end
    else
    begin
      next_state.prescale = state.prescale + 27'd1;
    end
    // Count decrements per tick and stops at zero
    if (state.tick && state.enable && state.count != wdog_pkg::COUNT_ZERO)
    begin
      next_state.count = state.count - wdog_pkg::COUNT_ONE;
    end
    // Control register write
    if (wr_control)
    begin
      next_state.enable  = i_pwdata[wdog_pkg::CTL_ENABLE_BIT];
      next_state.irq_en  = i_pwdata[wdog_pkg::CTL_IRQ_EN_BIT];
      next_state.rst_en  = i_pwdata[wdog_pkg::CTL_RST_EN_BIT];
      next_state.irq_sel = i_pwdata[wdog_pkg::CTL_SEL_LSB +: wdog_pkg::SEL_WIDTH];
    end
    // Timeout flag: set on trigger, cleared by count write or disable
    if (trigger)
    begin
      next_state.timeout = 1'b1;
    end
    else if (wr_count || !state.enable)
    begin
      next_state.timeout = 1'b0;
    end
    // Count write loads the full 8-bit seconds value
    if (wr_count)
    begin
      next_state.count = i_pwdata[wdog_pkg::COUNT_WIDTH-1:0];
    end
    // Board reset pulse on a trigger edge when enabled
    next_state.board_reset = 1'b0;
    if (state.pulse != 8'h00)
    begin
      next_state.pulse       = state.pulse - 8'h01;
      next_state.board_reset = 1'b1;
    end
    else if (trigger && !state.timeout && state.rst_en)
    begin
      next_state.pulse = 8'(wdog_pkg::RESET_PULSE_CYCLES);
    end
    // Interrupt lines registered from the per-line decoders
    next_state.irq_lines = irq_hit;
    // Read data and error response
    next_state.prdata  = 32'h0000_0000;
    next_state.pslverr = 1'b0;
    if (i_psel && !i_penable)
    begin
      next_state.pslverr = !known_addr;
      if (i_paddr == wdog_pkg::COUNT_ADDR)
      begin
        next_state.prdata[7:0] = state.count;
      end
      else if (i_paddr == wdog_pkg::CONTROL_ADDR)
      begin
        next_state.prdata[wdog_pkg::CTL_ENABLE_BIT] = state.enable;
        next_state.prdata[wdog_pkg::CTL_IRQ_EN_BIT] = state.irq_en;
        next_state.prdata[wdog_pkg::CTL_RST_EN_BIT] = state.rst_en;
        next_state.prdata[wdog_pkg::CTL_SEL_LSB +: wdog_pkg::SEL_WIDTH] = state.irq_sel;
      end
      else if (i_paddr == wdog_pkg::STATUS_ADDR)
      begin
        next_state.prdata[wdog_pkg::STS_TIMEOUT_BIT] = state.timeout;
        next_state.prdata[wdog_pkg::STS_ENABLE_BIT]  = state.enable;
      end
    end
  end

  // State register; watchdog comes up disabled
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs
  assign o_prdata      = state.prdata;
  assign o_pready      = 1'b1;
  assign o_pslverr     = state.pslverr && access;
  assign o_irq_lines   = state.irq_lines;
  assign o_board_reset = state.board_reset;
  assign o_timeout     = state.timeout;

  // Trigger sets the flag on the next edge
  property p_trigger_sets_flag;
    @(posedge i_sys_clk) disable iff (i_rst)
      trigger |=> state.timeout;
  endproperty
  a_trigger_sets_flag: assert property (p_trigger_sets_flag)
    else $error("zero count while enabled did not set timeout");

  // Count write without trigger clears the flag
  property p_write_clears;
    @(posedge i_sys_clk) disable iff (i_rst)
      (wr_count && !trigger) |=> !state.timeout;
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("count write did not clear timeout");

  // Disabled watchdog holds the flag low
  property p_disable_clears;
    @(posedge i_sys_clk) disable iff (i_rst)
      !state.enable |=> !state.timeout;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("timeout set while disabled");

  // Count holds its value unless a tick or a count write comes
  property p_count_step;
    @(posedge i_sys_clk) disable iff (i_rst)
      (!wr_count && !state.tick) |=> $stable(state.count);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count moved without tick or write");

  // Count never wraps below zero
  property p_no_wrap;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state.count == 8'h00 && !wr_count) |=> state.count == 8'h00;
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("count wrapped below zero");

  // Interrupt line follows flag and enable
  sequence s_irq_cause;
    state.timeout && state.irq_en;
  endsequence
  property p_irq_follow;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_irq_cause |=> o_irq_lines[$past(state.irq_sel)];
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("selected interrupt line not raised");

  // Interrupt drops when the flag is clear
  property p_irq_drop;
    @(posedge i_sys_clk) disable iff (i_rst)
      !state.timeout |=> o_irq_lines == 8'h00;
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("interrupt held without timeout");

  // No board reset unless reset enable was set
  property p_reset_gated;
    @(posedge i_sys_clk) disable iff (i_rst)
      (trigger && !state.timeout && !state.rst_en && state.pulse == 8'h00) |=> ##1 !o_board_reset;
  endproperty
  a_reset_gated: assert property (p_reset_gated)
    else $error("board reset without reset enable");

  // Tick only while enabled
  property p_tick_enabled;
    @(posedge i_sys_clk) disable iff (i_rst)
      state.tick |-> $past(state.enable);
  endproperty
  a_tick_enabled: assert property (p_tick_enabled)
    else $error("tick while disabled");

  // A tick takes exactly one second off a non-zero count
  property p_count_decrement;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state.tick && state.enable && !wr_count && (state.count != wdog_pkg::COUNT_ZERO))
        |=> (state.count == $past(state.count) - wdog_pkg::COUNT_ONE);
  endproperty
  a_count_decrement: assert property (p_count_decrement)
    else $error("tick did not take one off the count");

  // Ticks come only at the end of a full prescaler period
  property p_tick_period;
    @(posedge i_sys_clk) disable iff (i_rst)
      state.tick |-> ($past(state.prescale) == 27'(TICK_CYCLES - 1));
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick outside the prescaler period");

  // A fresh expiry with reset enabled starts the board reset pulse
  sequence s_fresh_expiry;
    trigger && !state.timeout && state.rst_en && (state.pulse == 8'h00);
  endsequence
  property p_reset_pulse_start;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_fresh_expiry |=> ##1 o_board_reset;
  endproperty
  a_reset_pulse_start: assert property (p_reset_pulse_start)
    else $error("board reset pulse did not start");

  // Interrupt lines stay low while the interrupt enable is clear
  property p_irq_gated;
    @(posedge i_sys_clk) disable iff (i_rst)
      !state.irq_en |=> (o_irq_lines == 8'h00);
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt raised with interrupt enable clear");

  // At most one interrupt line is driven
  property p_irq_one_hot;
    @(posedge i_sys_clk) disable iff (i_rst)
      $onehot0(o_irq_lines);
  endproperty
  a_irq_one_hot: assert property (p_irq_one_hot)
    else $error("more than one interrupt line raised");

endmodule : seconds_watchdog_timer

// File: logic/wdog_pkg.sv
// Package with register map, field layout and timing constants of the seconds watchdog
package wdog_pkg;
  // Register byte addresses
  localparam logic [11:0] COUNT_ADDR    = 12'h000;
  localparam logic [11:0] CONTROL_ADDR  = 12'h004;
  localparam logic [11:0] STATUS_ADDR   = 12'h008;
  // Control register fields
  localparam int          CTL_ENABLE_BIT  = 0;
  localparam int          CTL_IRQ_EN_BIT  = 1;
  localparam int          CTL_RST_EN_BIT  = 2;
  localparam int          CTL_SEL_LSB     = 4;
  localparam int          SEL_WIDTH       = 3;
  localparam int          IRQ_LINES       = 8;
  // Status register fields
  localparam int          STS_TIMEOUT_BIT = 0;
  localparam int          STS_ENABLE_BIT  = 1;
  // Count width and reset values
  localparam int          COUNT_WIDTH     = 8;
  localparam logic [7:0]  COUNT_RESET     = 8'h00;
  localparam logic [7:0]  COUNT_ZERO      = 8'h00;
  localparam logic [7:0]  COUNT_ONE       = 8'h01;
  // Timing
  localparam int          CLOCK_HZ        = 100000000;
  localparam int          TICK_SECONDS    = 1;
  localparam int          TICK_CYCLES     = CLOCK_HZ * TICK_SECONDS;
  localparam int          RESET_PULSE_NS  = 1000;
  localparam int          RESET_PULSE_CYCLES = (RESET_PULSE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int          PULSE_WIDTH     = 8;
  localparam int          PRESCALE_WIDTH  = 27;
endpackage : wdog_pkg

// File: test/seconds_watchdog_timer_test.sv
// Self-checking bench for the seconds watchdog timer over APB
module seconds_watchdog_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          TICK = 10;
  localparam logic [31:0] EN   = 32'h1 << wdog_pkg::CTL_ENABLE_BIT;
  localparam logic [31:0] IE   = 32'h1 << wdog_pkg::CTL_IRQ_EN_BIT;
  localparam logic [31:0] RE   = 32'h1 << wdog_pkg::CTL_RST_EN_BIT;
  localparam logic [31:0] ST_T = 32'h1 << wdog_pkg::STS_TIMEOUT_BIT;
  localparam logic [31:0] ST_E = 32'h1 << wdog_pkg::STS_ENABLE_BIT;
  logic        i_sys_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_psel    = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite  = 1'b0;
  logic [11:0] i_paddr   = 12'h000;
  logic [31:0] i_pwdata  = 32'h0000_0000;
  logic [3:0]  i_pstrb   = 4'hf;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic [7:0]  o_irq_lines;
  logic        o_board_reset;
  logic        o_timeout;
  int          errors = 0;
  int          comparisons = 0;
  logic [31:0] rd;
  logic        err;
  int          n;

  seconds_watchdog_timer #(.TICK_CYCLES(TICK)) u_seconds_watchdog_timer (
    .i_sys_clk     (i_sys_clk),
    .i_rst         (i_rst),
    .i_psel        (i_psel),
    .i_penable     (i_penable),
    .i_pwrite      (i_pwrite),
    .i_paddr       (i_paddr),
    .i_pwdata      (i_pwdata),
    .i_pstrb       (i_pstrb),
    .o_prdata      (o_prdata),
    .o_pready      (o_pready),
    .o_pslverr     (o_pslverr),
    .o_irq_lines   (o_irq_lines),
    .o_board_reset (o_board_reset),
    .o_timeout     (o_timeout)
  );

  // Clock of 100 MHz
  always #5 i_sys_clk = ~i_sys_clk;

  // Print the verdict and end the run
  task summarize;
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Compare a seen value with the expected one
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_sys_clk);
      k++;
    end
    while (o_pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      errors++;
      summarize();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // Count edges until timeout (sel 0) or board reset (sel 1) equals v
  task wait_for(input int sel, input logic v, input int limit, output int cycles);
    cycles = 0;
    while ((sel == 0 ? o_timeout : o_board_reset) !== v)
    begin
      @(posedge i_sys_clk);
      cycles++;
      if (cycles > limit)
      begin
        errors++;
        summarize();
      end
    end
  endtask : wait_for

  // Main sequence
  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    check({o_timeout, o_board_reset, o_irq_lines}, 32'h0);
    apb(1'b0, wdog_pkg::STATUS_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, wdog_pkg::COUNT_ADDR, 32'h0000_0003);
    apb(1'b0, wdog_pkg::COUNT_ADDR, 32'h0);
    check(rd, 32'h0000_0003);
    check({31'h0, err}, 32'h0);
    // A write with byte lane 0 off leaves the count alone
    i_pstrb <= 4'h0;
    apb(1'b1, wdog_pkg::COUNT_ADDR, 32'h0000_0009);
    i_pstrb <= 4'hf;
    apb(1'b0, wdog_pkg::COUNT_ADDR, 32'h0);
    check(rd, 32'h0000_0003);
    apb(1'b0, 12'h00c, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, wdog_pkg::CONTROL_ADDR, EN | IE | RE | (32'h5 << wdog_pkg::CTL_SEL_LSB));
    wait_for(0, 1'b1, 100, n);
    check(32'(n >= 2 * TICK && n <= 3 * TICK + 5), 32'h1);
    @(posedge i_sys_clk);
    check({24'h0, o_irq_lines}, 32'h20);
    wait_for(1, 1'b1, 10, n);
    wait_for(1, 1'b0, 300, n);
    check(n, wdog_pkg::RESET_PULSE_CYCLES);
    apb(1'b0, wdog_pkg::COUNT_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, wdog_pkg::COUNT_ADDR, 32'h0000_0005);
    repeat (3) @(posedge i_sys_clk);
    check({o_timeout, o_irq_lines}, 32'h0);
    apb(1'b0, wdog_pkg::STATUS_ADDR, 32'h0);
    check(rd, ST_E);
    // Refreshing faster than one second keeps the watchdog quiet
    for (int r = 0; r < 6; r++)
    begin
      apb(1'b1, wdog_pkg::COUNT_ADDR, 32'h0000_0002);
      repeat (4) @(posedge i_sys_clk);
      check({o_timeout, o_board_reset}, 32'h0);
    end
    // Without refresh a count of two expires within one to two seconds
    wait_for(0, 1'b1, 100, n);
    check(32'(n >= TICK - 4 && n <= 2 * TICK), 32'h1);
    wait_for(1, 1'b1, 10, n);
    wait_for(1, 1'b0, 300, n);
    check(n, wdog_pkg::RESET_PULSE_CYCLES);
    // Zero count at enable triggers at once on every interrupt line
    for (int s = 0; s < wdog_pkg::IRQ_LINES; s++)
    begin
      apb(1'b1, wdog_pkg::CONTROL_ADDR, 32'h0);
      apb(1'b1, wdog_pkg::COUNT_ADDR, 32'h0);
      check({31'h0, o_timeout}, 32'h0);
      apb(1'b1, wdog_pkg::CONTROL_ADDR, EN | IE | (32'(s) << wdog_pkg::CTL_SEL_LSB));
      apb(1'b0, wdog_pkg::CONTROL_ADDR, 32'h0);
      check(rd, EN | IE | (32'(s) << wdog_pkg::CTL_SEL_LSB));
      repeat (3) @(posedge i_sys_clk);
      check({24'h0, o_irq_lines}, 32'h1 << s);
      check({31'h0, o_timeout}, 32'h1);
      check({31'h0, o_board_reset}, 32'h0);
    end
    apb(1'b1, wdog_pkg::CONTROL_ADDR, EN);
    repeat (3) @(posedge i_sys_clk);
    check({o_timeout, o_irq_lines}, 32'h100);
    apb(1'b0, wdog_pkg::STATUS_ADDR, 32'h0);
    check(rd, ST_T | ST_E);
    // Reset in mid-run leaves the watchdog disabled
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    check({o_timeout, o_board_reset, o_irq_lines}, 32'h0);
    apb(1'b0, wdog_pkg::CONTROL_ADDR, 32'h0);
    check(rd, 32'h0);
    summarize();
  end
endmodule : seconds_watchdog_timer_test
